/* rtl/ipc_pkg.sv */
/*
 Constants for the ingress priority classifier register bank.
 Assumes word-indexed registers on a 32-bit APB bus, byte address = 4 x index.
*/
package ipc_pkg;
   localparam int IPC_AW = 12;
   localparam int IPC_NREG = 47;
   // ----------------------------------------
   // Register indices, reset values and write masks
   // ----------------------------------------
   localparam logic [7:0] IPC_OFF [IPC_NREG] = '{
      8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
      8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22,
      8'h23, 8'h30, 8'h33, 8'h3a, 8'h3b, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42,
      8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c,
      8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53};
   localparam logic [15:0] IPC_RST [IPC_NREG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h000f,
      16'hffff, 16'h000f, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7fff,
      16'h03ff, 16'h0280, 16'h0692, 16'h0ba2, 16'h0e30, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] IPC_MASK [IPC_NREG] = '{
      16'h0040, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'h001f, 16'h00ff, 16'h1100, 16'h00ff, 16'h1100, 16'hffff, 16'h000f,
      16'hffff, 16'h000f, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0130, 16'h7fff,
      16'h01ff, 16'h7000, 16'h0e00, 16'h00ff, 16'hf100, 16'h00ff, 16'h1100, 16'h7fff,
      16'h03ff, 16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff, 16'h00ff, 16'h1100, 16'h00ff,
      16'h1100, 16'h00ff, 16'h1100, 16'h00ff, 16'h1100, 16'h00ff, 16'h1100};
   localparam int I_INB = 0, I_EUP = 1, I_ELO = 2, I_APP0 = 3, I_WANL = 8, I_WANH = 9;
   localparam int I_PNF = 10, I_PNP = 12, I_TCP = 14, I_UDP = 16, I_RST1 = 18, I_RST2 = 19;
   localparam int I_ETYPE = 20, I_BPL = 21, I_BPH = 22, I_PP15 = 23, I_PP68 = 24;
   localparam int I_PP9 = 25, I_PP10 = 26, I_TAG = 27, I_COS = 29, I_DSM0 = 31, I_DSC0 = 33;
   localparam int I_SOURCE_HW_ADDRESS = 37, I_VID = 39, I_IPA = 41, I_MCG = 43, I_ACL = 45;
   // ----------------------------------------
   // Field positions and codes
   // ----------------------------------------
   localparam int B_INB = 6, B_RSTEN = 15, B_WANMODE = 4, B_BPDUEN = 8, B_BPDU9 = 4;
   localparam int B_HI9 = 8, B_HI10 = 12, B_SPEC = 13, B_EDITION = 14, B_SWAP = 15;
   localparam int B_NOMATCH = 9, B_PP9 = 12, B_PP10 = 9;
   localparam logic [3:0] ACT_CPU = 4'h9, ACT_BOTH = 4'hb, ACT_DROP = 4'ha;
   localparam logic [3:0] CPU_PORT = 4'h9, PORT9 = 4'h8;
   // ----------------------------------------
   // Well-known application port ranges
   // ----------------------------------------
   localparam logic [15:0] APP_LO [15] = '{16'h0014, 16'h0016, 16'h0017, 16'h0019, 16'h0035,
      16'h0043, 16'h0045, 16'h0050, 16'h006e, 16'h0077, 16'h007b, 16'h0089, 16'h008f,
      16'h00a1, 16'h01bb};
   localparam logic [15:0] APP_HI [15] = '{16'h0015, 16'h0016, 16'h0017, 16'h0019, 16'h0035,
      16'h0044, 16'h0045, 16'h0050, 16'h006e, 16'h0077, 16'h007b, 16'h008b, 16'h008f,
      16'h00a2, 16'h01bb};
   localparam logic [15:0] IMAP_ALT = 16'h00dc;
   localparam int APP_IMAP = 12;
endpackage

/* rtl/ipc_cfg.sv */
/*
 Ingress priority classifier: APB register bank and per-frame decision logic.
 Assumes frame attributes come from the packet pipeline on pclk, one frame per
 cycle, and that user port slots A to D are matched upstream.
*/
`timescale 1ns/1ps
module ipc_cfg
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ipc_pkg::IPC_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frame attributes
   input wire logic frm_valid,
   input wire logic [3:0] frm_port,
   input wire logic frm_is_tcp,
   input wire logic frm_is_udp,
   input wire logic [15:0] frm_l4_port,
   input wire logic [3:0] frm_user_hit,
   input wire logic frm_to_wan,
   input wire logic frm_inband,
   input wire logic [9:0] frm_l3_type,
   input wire logic [15:0] frm_ethertype,
   input wire logic frm_is_bpdu,
   input wire logic frm_tagged,
   input wire logic [2:0] frm_pcp,
   input wire logic frm_special_tag,
   input wire logic frm_ip,
   input wire logic [5:0] frm_dscp,
   // Decisions
   output logic cls_valid,
   output logic cls_app_hit,
   output logic [4:0] cls_app_index,
   output logic [3:0] cls_app_action,
   output logic cls_app_prio_use,
   output logic [2:0] cls_app_queue,
   output logic cls_app_to_cpu,
   output logic cls_app_cpu_only,
   output logic cls_app_drop,
   output logic cls_wan_drop,
   output logic cls_inband_cpu,
   output logic cls_inband_drop,
   output logic cls_user_etype,
   output logic [1:0] cls_bpdu_action,
   output logic [2:0] cls_port_prio,
   output logic cls_tag_use,
   output logic [2:0] cls_tag_prio,
   output logic cls_ip_use,
   output logic [2:0] cls_ip_prio,
   output logic [4:0] cls_misc_en
);
   import ipc_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [6:0] lookup(input logic [IPC_AW-1:0] a);
      lookup = 7'h00;
      for (int i = 0; i < IPC_NREG; i++)
      begin
         if (a[1:0] == 2'b00 && a[IPC_AW-1:2] == {2'b00, IPC_OFF[i]})
         begin
            lookup = {1'b1, 6'(i)};
         end
      end
   endfunction

   function automatic logic port_en(input logic [15:0] lo, input logic [15:0] hi, input logic [3:0] p);
      port_en = (p < PORT9) ? lo[p[2:0]] : (p == PORT9) ? hi[B_HI9] : (p == CPU_PORT) ? hi[B_HI10] : 1'b0;
   endfunction

   function automatic logic [5:0] first_hit(input logic [19:0] v);
      first_hit = 6'h00;
      for (int i = 19; i >= 0; i--)
      begin
         if (v[i])
         begin
            first_hit = {1'b1, 5'(i)};
         end
      end
   endfunction

   function automatic logic [19:0] l4_match(input logic [15:0] n, input logic [15:0] lo_e,
      input logic [15:0] hi_e, input logic [3:0] usr);
      for (int i = 0; i < 15; i++)
      begin
         l4_match[i] = n >= APP_LO[i] && n <= APP_HI[i];
      end
      l4_match[APP_IMAP] = l4_match[APP_IMAP] | (n == IMAP_ALT);
      l4_match[18:15] = usr;
      l4_match[19] = n >= lo_e && n <= hi_e;
   endfunction

   // ----------------------------------------
   // APB register file
   // ----------------------------------------
   logic [15:0] reg_q [IPC_NREG];
   wire [6:0] hit_ix = lookup(paddr);
   wire mapped = hit_ix[6];
   wire [5:0] ix = hit_ix[5:0];
   wire wr_en = psel && penable && pwrite && mapped;
   wire rd_setup = psel && !penable && !pwrite;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Byte strobes are honoured per lane so a partial write cannot clobber the other byte.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < IPC_NREG; i++)
         begin
            reg_q[i] <= IPC_RST[i];
         end
      end
      else if (wr_en)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (pstrb[b])
            begin
               reg_q[ix][8*b +: 8] <= pwdata[8*b +: 8] & IPC_MASK[ix][8*b +: 8];
            end
         end
      end
   end

   // Read data is fetched during the setup cycle so it leaves a flip-flop with no wait state.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_setup)
      begin
         prdata <= mapped ? {16'h0000, reg_q[ix]} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Application port matching
   // ----------------------------------------
   wire [19:0] tcp_en = {reg_q[I_TCP+1][3:0], reg_q[I_TCP]};
   wire [19:0] udp_en = {reg_q[I_UDP+1][3:0], reg_q[I_UDP]};
   wire [19:0] l4_hit = l4_match(frm_l4_port, reg_q[I_ELO], reg_q[I_EUP], frm_user_hit);
   wire [19:0] app_ok = l4_hit & (({20{frm_is_tcp}} & tcp_en) | ({20{frm_is_udp}} & udp_en));
   wire pnf_en = port_en(reg_q[I_PNF], reg_q[I_PNF+1], frm_port);
   wire pnp_en = port_en(reg_q[I_PNP], reg_q[I_PNP+1], frm_port);
   wire [5:0] app_first = first_hit(app_ok);
   wire app_hit = app_first[5] && pnf_en;
   wire [79:0] act_all = {reg_q[I_APP0+4], reg_q[I_APP0+3], reg_q[I_APP0+2],
      reg_q[I_APP0+1], reg_q[I_APP0]};
   wire [3:0] app_act = app_hit ? act_all[{app_first[4:0], 2'b00} +: 4] : 4'h0;
   wire app_queue = !app_act[3];
   wire app_cpu_only = app_act == ACT_CPU;
   wire app_both = app_act == ACT_BOTH;
   wire app_drop = app_act == ACT_DROP;
   wire [19:0] wan_sel = {reg_q[I_WANH][3:0], reg_q[I_WANL]};
   wire wan_sel_hit = |(app_ok & wan_sel);
   wire wan_mode = reg_q[I_WANH][B_WANMODE];
   // Positive list filters every WAN-bound frame on an enabled port without a selected match.
   wire wan_drop = frm_to_wan && pnf_en && (wan_mode ? !wan_sel_hit : wan_sel_hit);

   // ----------------------------------------
   // In-band management
   // ----------------------------------------
   wire etype_hit = frm_ethertype == reg_q[I_ETYPE];
   wire [30:0] mgmt_type = {l4_hit & (frm_is_tcp || frm_is_udp ? 20'hfffff : 20'h00000),
      frm_l3_type[9:7], etype_hit, frm_l3_type[6:0]};
   wire [30:0] mgmt_allow = {reg_q[I_RST2][14:0], reg_q[I_RST1]};
   wire inb_en = reg_q[I_INB][B_INB];
   wire restrict_on = reg_q[I_RST2][B_RSTEN];
   // With restriction on, a frame carrying several types goes to the CPU only if every one of them is allowed.
   wire restrict_ok = (mgmt_type & ~mgmt_allow) == 31'h0;
   wire inb_cpu = frm_inband && inb_en && (!restrict_on || restrict_ok);
   wire inb_drop = frm_inband && !inb_cpu;

   // ----------------------------------------
   // BPDU, port and tag priority
   // ----------------------------------------
   wire bpdu_on = reg_q[I_BPH][B_BPDUEN];
   wire [1:0] bpdu_fld = (frm_port < PORT9) ? reg_q[I_BPL][{frm_port[2:0], 1'b0} +: 2] :
      (frm_port == PORT9) ? reg_q[I_BPH][B_BPDU9 +: 2] : 2'b00;
   // Reserved code 01 is passed through as forward so a bad setting cannot drop traffic.
   wire [1:0] bpdu_act = (frm_is_bpdu && bpdu_on && bpdu_fld[1]) ? bpdu_fld : 2'b00;
   wire [23:0] pp18 = {reg_q[I_PP68][8:0], reg_q[I_PP15][14:0]};
   wire [4:0] pp_lsb = 5'(frm_port[2:0]) * 5'd3;
   wire [2:0] port_prio = (frm_port < PORT9) ? pp18[pp_lsb +: 3] :
      (frm_port == PORT9) ? reg_q[I_PP9][B_PP9 +: 3] :
      (frm_port == CPU_PORT) ? reg_q[I_PP10][B_PP10 +: 3] : 3'h0;
   wire tag_pen = port_en(reg_q[I_TAG], reg_q[I_TAG+1], frm_port);
   wire spec_use = frm_port == CPU_PORT && frm_special_tag && reg_q[I_TAG+1][B_SPEC];
   wire tag_use = (frm_tagged && tag_pen) || spec_use;
   wire swap01 = !reg_q[I_TAG+1][B_EDITION] && reg_q[I_TAG+1][B_SWAP];
   wire [2:0] tag_prio = (swap01 && frm_pcp[2:1] == 2'b00) ? {2'b00, !frm_pcp[0]} : frm_pcp;

   // ----------------------------------------
   // DSCP priority
   // ----------------------------------------
   wire [47:0] cps = {reg_q[I_DSC0+3][11:0], reg_q[I_DSC0+2][11:0],
      reg_q[I_DSC0+1][11:0], reg_q[I_DSC0][11:0]};
   wire [23:0] dpr = {reg_q[I_DSM0+1][8:0], reg_q[I_DSM0][14:0]};
   logic [7:0] dmatch;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         dmatch[i] = cps[6*i +: 6] == frm_dscp;
      end
   end
   wire [5:0] d_first = first_hit({12'h000, dmatch});
   wire cos_en = port_en(reg_q[I_COS], reg_q[I_COS+1], frm_port);
   wire nomatch_ignore = reg_q[I_DSM0+1][B_NOMATCH];
   wire ip_use = frm_ip && cos_en && (d_first[5] || !nomatch_ignore);
   wire [2:0] ip_prio = d_first[5] ? dpr[5'(d_first[2:0]) * 5'd3 +: 3] : 3'h0;
   wire [4:0] misc_en = {port_en(reg_q[I_ACL], reg_q[I_ACL+1], frm_port),
      port_en(reg_q[I_MCG], reg_q[I_MCG+1], frm_port),
      port_en(reg_q[I_IPA], reg_q[I_IPA+1], frm_port),
      port_en(reg_q[I_VID], reg_q[I_VID+1], frm_port),
      port_en(reg_q[I_SOURCE_HW_ADDRESS], reg_q[I_SOURCE_HW_ADDRESS+1], frm_port)};

   // ----------------------------------------
   // Decision register
   // ----------------------------------------
   wire v = frm_valid;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cls_valid <= 1'b0;
         cls_app_hit <= 1'b0;
         cls_app_index <= 5'h00;
         cls_app_action <= 4'h0;
         cls_app_prio_use <= 1'b0;
         cls_app_queue <= 3'h0;
         cls_app_to_cpu <= 1'b0;
         cls_app_cpu_only <= 1'b0;
         cls_app_drop <= 1'b0;
         cls_wan_drop <= 1'b0;
         cls_inband_cpu <= 1'b0;
         cls_inband_drop <= 1'b0;
         cls_user_etype <= 1'b0;
         cls_bpdu_action <= 2'b00;
         cls_port_prio <= 3'h0;
         cls_tag_use <= 1'b0;
         cls_tag_prio <= 3'h0;
         cls_ip_use <= 1'b0;
         cls_ip_prio <= 3'h0;
         cls_misc_en <= 5'h00;
      end
      else
      begin
         cls_valid <= v;
         cls_app_hit <= v && app_hit;
         cls_app_index <= app_first[4:0];
         cls_app_action <= app_act;
         cls_app_prio_use <= v && app_hit && pnp_en && app_queue && app_act != 4'h0;
         cls_app_queue <= app_queue ? app_act[2:0] : 3'h0;
         cls_app_to_cpu <= v && (app_cpu_only || app_both);
         cls_app_cpu_only <= v && app_cpu_only;
         cls_app_drop <= v && app_drop;
         cls_wan_drop <= v && wan_drop;
         cls_inband_cpu <= v && inb_cpu;
         cls_inband_drop <= v && inb_drop;
         cls_user_etype <= v && etype_hit;
         cls_bpdu_action <= v ? bpdu_act : 2'b00;
         cls_port_prio <= port_prio;
         cls_tag_use <= v && tag_use;
         cls_tag_prio <= tag_prio;
         cls_ip_use <= v && ip_use;
         cls_ip_prio <= ip_prio;
         cls_misc_en <= v ? misc_en : 5'h00;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [5:0] last_ix;
   logic [15:0] last_data;
   logic last_ok;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_ok <= 1'b0;
         last_ix <= 6'h00;
         last_data <= 16'h0000;
      end
      else if (wr_en)
      begin
         last_ok <= pstrb[1:0] == 2'b11;
         last_ix <= ix;
         last_data <= pwdata[15:0];
      end
   end
   sequence rd_access_s;
      psel && penable && !pwrite && mapped && ix == last_ix && last_ok;
   endsequence
   // Readback is only checked after a full-width write, since a partial write leaves a lane untracked here.
   readback_a: assert property (rd_access_s |-> prdata[15:0] == (last_data & IPC_MASK[last_ix])
      && prdata[31:16] == 16'h0000) else $error("readback mismatch");
   pnf_gate_a: assert property (v && !pnf_en |=> !cls_app_hit && !cls_wan_drop)
      else $error("port function not gated");
   // A hit on a port without priority enable still acts, but must never raise cls_app_prio_use.
   prio_gate_a: assert property (v && !pnp_en |=> !cls_app_prio_use)
      else $error("port priority not gated");
   proto_gate_a: assert property (v && !frm_is_tcp && !frm_is_udp |=> !cls_app_hit)
      else $error("non tcp udp matched");
   // Either protocol may carry the user E range, so both enables qualify the check.
   range_e_a: assert property (v && pnf_en && ((frm_is_tcp && tcp_en[19]) || (frm_is_udp && udp_en[19]))
      && app_ok[18:0] == 19'h0 && frm_l4_port >= reg_q[I_ELO] && frm_l4_port <= reg_q[I_EUP]
      |=> cls_app_hit && cls_app_index == 5'd19) else $error("range e missed");
   drop_code_a: assert property (cls_app_action == ACT_DROP && cls_app_hit |-> cls_app_drop
      && !cls_app_to_cpu && !cls_app_prio_use) else $error("drop code decode");
   cpu_code_a: assert property (cls_app_action == ACT_CPU && cls_app_hit |-> cls_app_cpu_only
      && cls_app_to_cpu && !cls_app_drop && !cls_app_prio_use) else $error("cpu code decode");
   wan_neg_a: assert property (v && pnf_en && frm_to_wan && !wan_mode && wan_sel_hit |=> cls_wan_drop)
      else $error("negative list not filtered");
   inband_off_a: assert property (v && frm_inband && !inb_en |=> cls_inband_drop && !cls_inband_cpu)
      else $error("in-band not dropped");
   bpdu_off_a: assert property (v && !bpdu_on |=> cls_bpdu_action == 2'b00)
      else $error("bpdu acted while off");
   // Registers are compared one edge back because a write may land on the same edge as the frame.
   port9_prio_a: assert property (v && frm_port == PORT9 |=> cls_port_prio == $past(reg_q[I_PP9][14:12]))
      else $error("port 9 priority wrong");
   tag_swap_a: assert property (v && !reg_q[I_TAG+1][B_EDITION] && reg_q[I_TAG+1][B_SWAP] && frm_pcp == 3'h0
      |=> cls_tag_prio == 3'h1) else $error("tag swap missing");
   nomatch_a: assert property (v && frm_ip && cos_en && dmatch == 8'h00 |=> cls_ip_use
      == !$past(nomatch_ignore) && cls_ip_prio == 3'h0) else $error("dscp no-match wrong");
endmodule // ipc_cfg

/* verif/tb.sv */
/*
 Self-checking bench for the ingress priority classifier register bank.
 Assumes ipc_pkg and ipc_cfg from rtl/, APB with byte address = 4 x index.
*/
`timescale 1ns/1ps
module tb;
   import ipc_pkg::*;
   // ----------------------------------------
   // Signals and scoreboard
   // ----------------------------------------
   localparam logic [28:0] M_APP = 29'h0fe0000, M_WAN = 29'h10000, M_INB = 29'hc000, M_ETY = 29'h2000;
   localparam logic [28:0] M_BP = 29'h1800, M_PP = 29'h700, M_TU = 29'h80, M_TAG = 29'hf0;
   localparam logic [28:0] M_IU = 29'h8, M_IP = 29'hf, M_MISC = 29'h1f000000;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [IPC_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf, frm_port = 4'h0, frm_user_hit = 4'h0;
   logic frm_valid = 0, frm_is_tcp = 0, frm_is_udp = 0, frm_to_wan = 0, frm_inband = 0;
   logic frm_is_bpdu = 0, frm_tagged = 0, frm_special_tag = 0, frm_ip = 0;
   logic [15:0] frm_l4_port = '0, frm_ethertype = '0;
   logic [9:0] frm_l3_type = '0;
   logic [2:0] frm_pcp = '0;
   logic [5:0] frm_dscp = '0;
   logic [31:0] prdata;
   logic pready, pslverr, cls_valid, cls_app_hit, cls_app_to_cpu, cls_app_drop, cls_wan_drop;
   logic cls_inband_cpu, cls_inband_drop, cls_user_etype, cls_tag_use, cls_ip_use;
   logic [3:0] cls_app_action;
   logic [1:0] cls_bpdu_action;
   logic [2:0] cls_port_prio, cls_tag_prio, cls_ip_prio;
   logic [4:0] cls_misc_en, cls_app_index;
   logic cls_app_prio_use, cls_app_cpu_only;
   logic [2:0] cls_app_queue;
   logic [28:0] obs;
   logic [33:0] aq[$];
   logic [68:0] fq[$];
   int n_mismatch = 0, checks = 0, cyc = 0;
   logic [31:0] seed = 32'hb952;
   assign obs = {cls_misc_en, cls_app_hit, cls_app_action, cls_app_to_cpu, cls_app_drop, cls_wan_drop,
      cls_inband_cpu, cls_inband_drop, cls_user_etype, cls_bpdu_action, cls_port_prio, cls_tag_use,
      cls_tag_prio, cls_ip_use, cls_ip_prio};
   always #20 pclk = ~pclk;
   ipc_cfg dut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .frm_valid, .frm_port, .frm_is_tcp, .frm_is_udp, .frm_l4_port, .frm_user_hit, .frm_to_wan, .frm_inband,
      .frm_l3_type, .frm_ethertype, .frm_is_bpdu, .frm_tagged, .frm_pcp, .frm_special_tag, .frm_ip, .frm_dscp,
      .cls_valid, .cls_app_hit, .cls_app_index, .cls_app_action, .cls_app_prio_use, .cls_app_queue,
      .cls_app_to_cpu, .cls_app_cpu_only, .cls_app_drop, .cls_wan_drop, .cls_inband_cpu, .cls_inband_drop,
      .cls_user_etype, .cls_bpdu_action, .cls_port_prio, .cls_tag_use, .cls_tag_prio, .cls_ip_use, .cls_ip_prio,
      .cls_misc_en
   );
   // ----------------------------------------
   // Helpers and bus tasks
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Hi registers keep port 9 in bit 8 and port 10 in bit 12.
   function automatic logic pbit(input logic [15:0] v, input int p);
      return (p < 8) ? v[p] : (p == 8) ? v[8] : v[12];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Upper data half carries junk on purpose, so a read that returns it shows up.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d, input logic [33:0] exp);
      aq.push_back(exp);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {d, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      apb(1'b1, idx, d, 34'h0);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [15:0] e);
      apb(1'b0, idx, 16'h0, {2'b10, 16'h0, e});
   endtask
   task automatic fr(input logic [28:0] m, input logic [28:0] v, input logic [10:0] a = 11'h0);
      fq.push_back({a, m, v & m});
      @(posedge pclk);
      frm_valid <= 1'b1;
      @(posedge pclk);
      frm_valid <= 1'b0;
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && checks > 0 && aq.size() == 0 && fq.size() == 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // Monitor and timeout
   // ----------------------------------------
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && aq.size() > 0)
      begin
         chk(pslverr, aq[0][32]);
         if (aq[0][33])
            chk(prdata, aq[0][31:0]);
         void'(aq.pop_front());
      end
      if (cls_valid === 1'b1 && fq.size() == 0)
         chk(cls_valid, 1'b0);
      else if (cls_valid === 1'b1)
      begin
         chk(obs & fq[0][57:29], fq[0][28:0]);
         if (fq[0][68])
            chk({cls_app_index, cls_app_prio_use, cls_app_queue, cls_app_cpu_only}, fq[0][67:58]);
         void'(fq.pop_front());
      end
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      logic [15:0] v, w;
      logic [15:0] rv [12];
      logic [7:0] ra [12] = '{8'h30, 8'h33, 8'h3a, 8'h3b, 8'h3e, 8'h3f, 8'h40, 8'h4a, 8'h4c, 8'h4e, 8'h50, 8'h52};
      int ep [4] = '{899, 900, 1000, 1001};
      logic [3:0] act;
      logic [2:0] pr [8];
      logic [5:0] cp [8];
      logic [2:0] q;
      logic [1:0] b;
      logic hit;
      logic [10:0] ax;
      int j;
      // Second pass resets over random contents, so defaults must come back.
      for (int pass = 0; pass < 2; pass++)
      begin
         do_reset();
         for (int i = 0; i < IPC_NREG; i++)
            rd(IPC_OFF[i], IPC_RST[i]);
         for (int i = 0; i < IPC_NREG; i++)
         begin
            v = 16'(xs());
            wr(IPC_OFF[i], v);
            rd(IPC_OFF[i], v & IPC_MASK[i]);
         end
      end
      apb(1'b1, 8'h24, 16'h1234, {2'b01, 32'h0});
      apb(1'b0, 8'h24, 16'h0, {2'b11, 32'h0});
      do_reset();
      wr(8'h19, 16'h0001);
      wr(8'h1b, 16'h0001);
      frm_is_tcp <= 1'b1;
      for (int k = 0; k < 15; k++)
      begin
         act = (k % 10 < 7) ? 4'(k % 10 + 1) : 4'(k % 10 + 2);
         wr(8'(8'h12 + k / 4), 16'(act) << (4 * (k % 4)));
         frm_l4_port <= (k % 2) ? APP_HI[k] : APP_LO[k];
         hit = act == 4'h9 || act == 4'hb;
         ax = {1'b1, 5'(k), act < 4'h8, act < 4'h8 ? act[2:0] : 3'h0, act == 4'h9};
         fr(M_APP, {5'h0, 1'b1, act, hit, act == 4'ha, 17'h0}, ax);
      end
      frm_port <= 4'h1;
      fr(M_APP, 29'h0);
      frm_port <= 4'h0;
      wr(8'h1d, 16'h0000);
      fr(M_APP, 29'h0);
      frm_is_tcp <= 1'b0;
      frm_is_udp <= 1'b1;
      fr(M_APP, {5'h0, 1'b1, 4'h5, 2'b00, 17'h0}, {1'b1, 5'd14, 1'b1, 3'h5, 1'b0});
      wr(8'h10, 16'd1000);
      wr(8'h11, 16'd900);
      wr(8'h16, 16'h5030);
      for (int k = 0; k < 4; k++)
      begin
         frm_l4_port <= 16'(ep[k]);
         hit = (k == 1 || k == 2);
         fr(M_APP, {5'h0, hit, hit ? 4'h5 : 4'h0, 19'h0}, hit ? {1'b1, 5'd19, 1'b1, 3'h5, 1'b0} : 11'h0);
      end
      frm_user_hit <= 4'h4;
      fr(M_APP, {5'h0, 1'b1, 4'h3, 19'h0}, {1'b1, 5'd17, 1'b1, 3'h3, 1'b0});
      frm_user_hit <= 4'h0;
      frm_to_wan <= 1'b1;
      wr(8'h17, 16'h0008);
      for (int m = 0; m < 2; m++)
      begin
         wr(8'h18, 16'(m) << 4);
         for (int s = 0; s < 2; s++)
         begin
            frm_l4_port <= s ? APP_LO[3] : APP_LO[7];
            hit = (m == 1) ? (s == 0) : (s == 1);
            fr(M_WAN, {12'h0, hit, 16'h0});
         end
      end
      frm_to_wan <= 1'b0;
      frm_is_udp <= 1'b0;
      frm_inband <= 1'b1;
      frm_ethertype <= 16'h0800;
      wr(8'h21, 16'h0001);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h01, (k > 0) ? 16'h0040 : 16'h0000);
         wr(8'h22, (k > 1) ? 16'h8000 : 16'h0000);
         frm_l3_type <= (k == 3) ? 10'h002 : 10'h001;
         hit = (k == 1 || k == 2);
         fr(M_INB, {13'h0, hit, !hit, 14'h0});
      end
      frm_inband <= 1'b0;
      v = 16'(xs());
      wr(8'h23, v);
      for (int k = 0; k < 2; k++)
      begin
         frm_ethertype <= v ^ 16'(k);
         fr(M_ETY, {15'h0, k == 0, 13'h0});
      end
      for (int k = 0; k < 12; k++)
      begin
         rv[k] = (k == 1) ? (16'(xs()) | 16'h0100) : 16'(xs());
         wr(ra[k], rv[k]);
         if (k > 5)
            wr(8'(ra[k] + 1), rv[k] & 16'h1100);
      end
      frm_is_bpdu <= 1'b1;
      frm_tagged <= 1'b1;
      for (int p = 0; p < 10; p++)
      begin
         frm_port <= 4'(p);
         b = (p < 8) ? rv[0][2*p+:2] : (p == 8) ? rv[1][5:4] : 2'b00;
         b = (b == 2'b01) ? 2'b00 : b;
         q = (p < 5) ? rv[2][3*p+:3] : (p < 8) ? rv[3][3*(p-5)+:3] : (p == 8) ? rv[4][14:12] : rv[5][11:9];
         fr(M_BP | M_PP | M_TU | M_MISC, {pbit(rv[11], p), pbit(rv[10], p), pbit(rv[9], p), pbit(rv[8], p),
            pbit(rv[7], p), 11'h0, b, q, pbit(rv[6], p), 7'h0});
      end
      frm_is_bpdu <= 1'b0;
      frm_port <= 4'h0;
      wr(8'h40, 16'h0001);
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h41, (c == 0) ? 16'h0000 : (c == 1) ? 16'h8000 : 16'hc000);
         for (int s = 0; s < 8; s++)
         begin
            frm_pcp <= 3'(s);
            q = (c == 1 && s < 2) ? 3'(s ^ 1) : 3'(s);
            fr(M_TAG, {21'h0, 1'b1, q, 4'h0});
         end
      end
      frm_tagged <= 1'b0;
      frm_special_tag <= 1'b1;
      frm_port <= 4'h9;
      wr(8'h41, 16'h2000);
      fr(M_TU, {21'h0, 1'b1, 7'h0});
      frm_special_tag <= 1'b0;
      frm_port <= 4'h0;
      frm_ip <= 1'b1;
      wr(8'h42, 16'h0001);
      v = 16'(xs());
      w = 16'(xs());
      for (int k = 0; k < 4; k++)
      begin
         rv[k] = 16'(xs());
         wr(8'(8'h46 + k), rv[k]);
         cp[2*k] = rv[k][5:0];
         cp[2*k+1] = rv[k][11:6];
      end
      for (int k = 0; k < 8; k++)
         pr[k] = (k < 5) ? v[3*k+:3] : w[3*(k-5)+:3];
      for (int c = 0; c < 2; c++)
      begin
         wr(8'h44, v);
         wr(8'h45, {6'h0, c[0], w[8:0]});
         for (int d = 0; d < 64; d++)
         begin
            frm_dscp <= 6'(d);
            j = 8;
            for (int k = 7; k >= 0; k--)
               j = (cp[k] == 6'(d)) ? k : j;
            if (j < 8)
               fr(M_IU | M_IP, {25'h0, 1'b1, pr[j]});
            else if (c == 0)
               fr(M_IU | M_IP, {25'h0, 1'b1, 3'h0});
            else
               fr(M_IU, 29'h0);
         end
      end
      frm_port <= 4'h1;
      fr(M_IU, 29'h0);
      repeat (4) @(posedge pclk);
      test_done();
   end
endmodule // tb
